// ==== bench/bleg_checker.sv ====
`timescale 1ns/100ps
// watches the b leg selector and both shifters at the top ports
module bleg_checker
(
    input wire logic                 SYS_CLK,
    input wire logic                 RST,
    input wire logic [15:0]          WRITEBACK_SOURCE_MUX,
    input wire bleg_pkg::shift_ctl_t SHIFT_CTL,
    input wire bleg_pkg::bsel_t      B_SEL,
    input wire logic                 SUPPRESS_UNIT_CONSTANT,
    input wire logic [15:0]          B_OPERAND,
    input wire logic [15:0]          UPPER_Q,
    input wire logic [15:0]          LOWER_Q
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // selector has no register, so it must agree in the same cycle
    a_bsel_upper: assert property (
        B_SEL == bleg_pkg::BSEL_UPPER |-> B_OPERAND == UPPER_Q)
        else $error("b operand not upper");
    a_bsel_lower: assert property (
        B_SEL == bleg_pkg::BSEL_LOWER |-> B_OPERAND == LOWER_Q)
        else $error("b operand not lower");
    a_bsel_sixteen: assert property (
        B_SEL == bleg_pkg::BSEL_SIXTEEN |-> B_OPERAND == 16'h0010)
        else $error("b operand not sixteen");
    a_unit_const: assert property (
        B_SEL == bleg_pkg::BSEL_UNIT |->
        B_OPERAND == {15'h0000, !SUPPRESS_UNIT_CONSTANT})
        else $error("b operand unit constant wrong");
    // shifter effects show one edge after the mode is sampled
    a_upper_hold: assert property (
        SHIFT_CTL.upper_mode == bleg_pkg::MODE_HOLD |=> $stable(UPPER_Q))
        else $error("upper moved on hold");
    a_lower_load: assert property (
        SHIFT_CTL.lower_mode == bleg_pkg::MODE_LOAD |=>
        LOWER_Q == $past(WRITEBACK_SOURCE_MUX))
        else $error("lower load wrong");
    a_chain_right: assert property (
        SHIFT_CTL.lower_mode == bleg_pkg::MODE_RIGHT |=>
        LOWER_Q[15] == $past(UPPER_Q[0]))
        else $error("lower msb not from upper bit 0");
    a_upper_left: assert property (
        SHIFT_CTL.upper_mode == bleg_pkg::MODE_LEFT |=>
        UPPER_Q[0] == $past(SHIFT_CTL.shift_in_upper))
        else $error("upper left shift-in wrong");
    c_zero: cover property (B_SEL == 2'b11 && SUPPRESS_UNIT_CONSTANT);
    c_chain: cover property (SHIFT_CTL.lower_mode == 2'b01);
    c_load: cover property (SHIFT_CTL.upper_mode == 2'b11);
endmodule

// ==== bench/ctl_store_model.sv ====
`timescale 1ns/100ps
// control store stand-in: slices one microword into the block's selects
module ctl_store_model
(
    input  wire logic [31:0]    uword,
    output logic [15:0]         wb,
    output bleg_pkg::shift_ctl_t ctl,
    output bleg_pkg::bsel_t     bsel,
    output logic                sup
);
    // word only changes after an edge, so selects settle before sampling
    assign ctl = bleg_pkg::shift_ctl_t'(uword[7:0]);
    assign bsel = bleg_pkg::bsel_t'(uword[9:8]);
    assign sup = uword[10];
    assign wb = uword[26:11];
endmodule

// ==== bench/scratchpad_and_b_operand_leg_tb.sv ====
`timescale 1ns/100ps
module scratchpad_and_b_operand_leg_tb;
    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    logic [31:0]          uword = 32'h0;
    bleg_pkg::ss_req_t    ss = '0;
    logic [15:0]          wb, alu_a, mmu, b_op, up_q, lo_q, eu, el;
    bleg_pkg::shift_ctl_t ctl;
    bleg_pkg::bsel_t      bsel;
    logic                 sup;
    logic [15:0]          mem [16];
    logic [31:0]          corner [4] = '{32'h040008f0, 32'h0000075a,
                                         32'h000002a5, 32'h00000100};
    int                   miscompares = 0;
    int                   total_checks = 0;

    always #2.5 clk = ~clk;
    ctl_store_model cs (.uword(uword), .wb(wb), .ctl(ctl), .bsel(bsel),
        .sup(sup));
    scratchpad_and_b_operand_leg dut (.SYS_CLK(clk), .RST(rst), .SS_REQ(ss),
        .WRITEBACK_SOURCE_MUX(wb), .SHIFT_CTL(ctl), .B_SEL(bsel),
        .SUPPRESS_UNIT_CONSTANT(sup), .ALU_A_OPERAND(alu_a),
        .MMU_SCRATCH_DATA(mmu), .B_OPERAND(b_op), .UPPER_Q(up_q),
        .LOWER_Q(lo_q));

    task automatic check(input string n, input logic [15:0] s, e);
        total_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // reference shifters; byte right shift swaps only the bit 7 source
    function automatic logic [15:0] nup(input logic [15:0] u);
        logic [15:0] r;
        r = {ctl.shift_in_upper, u[15:1]};
        if (ctl.byte_op)
            r[7] = ctl.serial_shift;
        case (ctl.upper_mode)
            bleg_pkg::MODE_HOLD:  nup = u;
            bleg_pkg::MODE_RIGHT: nup = r;
            bleg_pkg::MODE_LEFT:  nup = {u[14:0], ctl.shift_in_upper};
            default:              nup = wb;
        endcase
    endfunction

    function automatic logic [15:0] nlo(input logic [15:0] l, u);
        case (ctl.lower_mode)
            bleg_pkg::MODE_HOLD:  nlo = l;
            bleg_pkg::MODE_RIGHT: nlo = {u[0], l[15:1]};
            bleg_pkg::MODE_LEFT:  nlo = {l[14:0], ctl.shift_in_lower};
            default:              nlo = wb;
        endcase
    endfunction

    function automatic logic [15:0] eb();
        case (bsel)
            bleg_pkg::BSEL_UPPER:   eb = eu;
            bleg_pkg::BSEL_LOWER:   eb = el;
            bleg_pkg::BSEL_SIXTEEN: eb = 16'h0010;
            default:                eb = {15'h0000, !sup};
        endcase
    endfunction

    // main sequence: scratch fill and readback, then shifter traffic
    initial
    begin
        void'($urandom(32'h6837fc0e));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            mem[i] = 16'($urandom);
            @(posedge clk);
            ss <= '{4'(i), 1'b1, 4'(i), mem[i]};
        end
        @(posedge clk);
        ss.wr_en <= 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            ss.addr <= 4'(i);
            @(posedge clk);
            @(negedge clk);
            check("scratch", alu_a, mem[i]);
            check("mmu", mmu, mem[i]);
            @(posedge clk);
        end
        eu = 16'h0000;
        el = 16'h0000;
        // corner microwords first, random ones after
        for (int n = 0; n < 600; n++)
        begin
            @(posedge clk);
            uword <= (n < 4) ? corner[n] : $urandom;
            @(negedge clk);
            check("upper", up_q, eu);
            check("lower", lo_q, el);
            check("b operand", b_op, eb());
            el = nlo(el, eu);
            eu = nup(eu);
        end
        stop_test();
    end

    // run takes about 3.3 us; six times that means a hang
    initial
    begin
        #20000;
        miscompares++;
        stop_test();
    end
endmodule

bind scratchpad_and_b_operand_leg bleg_checker chk (.SYS_CLK, .RST,
    .WRITEBACK_SOURCE_MUX, .SHIFT_CTL, .B_SEL, .SUPPRESS_UNIT_CONSTANT,
    .B_OPERAND, .UPPER_Q, .LOWER_Q);

// ==== hdl/operand_shifter.sv ====
`timescale 1ns/100ps
// one 16-bit universal shift register: hold, right, left, load
module operand_shifter
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire bleg_pkg::shift_mode_t mode,
    input  wire logic [15:0]           load_data,
    input  wire logic                  right_in,
    input  wire logic                  left_in,
    input  wire logic                  byte_op,
    input  wire logic                  byte_in,
    output logic [15:0]                q
);
    logic [15:0] q_reg;
    logic [15:0] right_val;

    // byte right shift feeds bit 7 from the byte input instead of bit 8
    always_comb
    begin
        right_val = {right_in, q_reg[15:1]};
        if (byte_op)
            right_val[bleg_pkg::BYTE_MSB] = byte_in;
    end

    // mode action on each rising edge
    always_ff @(posedge clk)
    begin
        if (rst)
            q_reg <= bleg_pkg::WORD_RESET;
        else
        begin
            case (mode)
                bleg_pkg::MODE_HOLD:  q_reg <= q_reg;
                bleg_pkg::MODE_RIGHT: q_reg <= right_val;
                bleg_pkg::MODE_LEFT:  q_reg <= {q_reg[14:0], left_in};
                bleg_pkg::MODE_LOAD:  q_reg <= load_data;
                default:              q_reg <= q_reg;
            endcase
        end
    end

    assign q = q_reg;
endmodule

// ==== hdl/scratchpad_and_b_operand_leg.sv ====
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
// Functional notes
// - scratch store holds sixteen 16-bit words, readable and writable
// - entries 0-5 general, 6 stack pointer, 7 program counter, rest temps
// - octal entry 16 holds the user-mode stack pointer
// - scratch read data feeds ALU A operand and memory management
// - both shifters load from the writeback source mux
// - modes: hold, shift right, shift left, parallel load per clock
// - lower shifter has its own mode selects
// - upper shifter shifts as byte or word
// - upper shifter shift-in comes from a dedicated serial input
// - in 32-bit right shift lower msb fills from upper bit 0
// - upper shifter is the high half of the double word
// - selects 00 pass upper shifter to B operand
// - selects 01 pass lower shifter
// - selects 10 give constant +16
// - selects 11 without suppress give +1
// - selects 11 with suppress give 0; carry-in adds the unit
// - select bit 1 high forces operand bits 15:5 to zero
// - byte right shift loads bit 7 from serial input, else bit 8
module scratchpad_and_b_operand_leg
(
    input  wire logic                 SYS_CLK,
    input  wire logic                 RST,
    input  wire bleg_pkg::ss_req_t    SS_REQ,
    input  wire logic [15:0]          WRITEBACK_SOURCE_MUX,
    input  wire bleg_pkg::shift_ctl_t SHIFT_CTL,
    input  wire bleg_pkg::bsel_t      B_SEL,
    input  wire logic                 SUPPRESS_UNIT_CONSTANT,
    output logic [15:0]               ALU_A_OPERAND,
    output logic [15:0]               MMU_SCRATCH_DATA,
    output logic [15:0]               B_OPERAND,
    output logic [15:0]               UPPER_Q,
    output logic [15:0]               LOWER_Q
);
    // scratch store and its registered read side
    logic [15:0] scratch_store [bleg_pkg::SS_DEPTH];
    logic [15:0] wr_hit;
    logic [15:0] read_next;
    logic [15:0] read_reg;

    // serial inputs of both shifters and their contents
    logic        upper_right_in;
    logic        upper_left_in;
    logic        upper_byte_op;
    logic        upper_byte_in;
    logic        lower_right_in;
    logic        lower_left_in;
    logic [15:0] upper_q;
    logic [15:0] lower_q;

    // b operand selector: decoded paths, register pick, three slices
    logic        pass_upper;
    logic        pass_lower;
    logic        gen_sixteen;
    logic        gen_unit;
    logic        high_enable;
    logic [15:0] reg_pick;
    logic [15:0] high_part;
    logic [15:0] low_part;
    logic [15:0] const_part;
    logic [15:0] b_next;

    // one-hot write enable; nothing is written while wr_en is low
    always_comb
    begin
        wr_hit = '0;
        for (int i = 0; i < bleg_pkg::SS_DEPTH; i++)
        begin
            if (SS_REQ.wr_en && (int'(SS_REQ.wr_addr) == i))
                wr_hit[i] = 1'b1;
        end
    end

    // write on the rising edge; contents are not cleared by reset,
    // so microcode must load an entry before it reads it
    always_ff @(posedge SYS_CLK)
    begin
        for (int i = 0; i < bleg_pkg::SS_DEPTH; i++)
        begin
            if (wr_hit[i])
                scratch_store[i] <= SS_REQ.wr_data;
        end
    end

    // read address looked at every edge; a write to the same entry
    // in that cycle is only seen by the next read
    always_comb
    begin
        read_next = scratch_store[SS_REQ.addr];
    end

    // registered read, like the latched output buffer of the store;
    // roles of entries (sp, pc, user sp) are fixed by microcode use only
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
            read_reg <= bleg_pkg::WORD_RESET;
        else
            read_reg <= read_next;
    end

    // one read value drives both consumers
    assign ALU_A_OPERAND = read_reg;
    assign MMU_SCRATCH_DATA = read_reg;

    // upper half: one dedicated serial bit feeds both shift ends
    always_comb
    begin
        upper_right_in = SHIFT_CTL.shift_in_upper;
        upper_left_in = SHIFT_CTL.shift_in_upper;
        upper_byte_op = SHIFT_CTL.byte_op;
        upper_byte_in = SHIFT_CTL.serial_shift;
    end

    // lower half: right input chained from upper bit 0 so a
    // right shift of both halves moves the double word as one
    always_comb
    begin
        lower_right_in = upper_q[0];
        lower_left_in = SHIFT_CTL.shift_in_lower;
    end

    // upper half of the double word, byte/word shifts
    operand_shifter u_upper
    (
        .clk       (SYS_CLK),
        .rst       (RST),
        .mode      (SHIFT_CTL.upper_mode),
        .load_data (WRITEBACK_SOURCE_MUX),
        .right_in  (upper_right_in),
        .left_in   (upper_left_in),
        .byte_op   (upper_byte_op),
        .byte_in   (upper_byte_in),
        .q         (upper_q)
    );

    // lower half; own mode pair so both halves may differ in one cycle
    operand_shifter u_lower
    (
        .clk       (SYS_CLK),
        .rst       (RST),
        .mode      (SHIFT_CTL.lower_mode),
        .load_data (WRITEBACK_SOURCE_MUX),
        .right_in  (lower_right_in),
        .left_in   (lower_left_in),
        .byte_op   (1'b0),
        .byte_in   (1'b0),
        .q         (lower_q)
    );

    // selector code decode; exactly one path is live per code
    always_comb
    begin
        pass_upper = 1'b0;
        pass_lower = 1'b0;
        gen_sixteen = 1'b0;
        gen_unit = 1'b0;
        case (B_SEL)
            bleg_pkg::BSEL_UPPER:
            begin
                pass_upper = 1'b1;
            end
            bleg_pkg::BSEL_LOWER:
            begin
                pass_lower = 1'b1;
            end
            bleg_pkg::BSEL_SIXTEEN:
            begin
                gen_sixteen = 1'b1;
            end
            bleg_pkg::BSEL_UNIT:
            begin
                gen_unit = 1'b1;
            end
            default:
            begin
                pass_upper = 1'b1;
            end
        endcase
    end

    // select bit 1 high means a constant code: register bits stay out
    always_comb
    begin
        high_enable = !(gen_sixteen || gen_unit);
    end

    // register source shared by the high and low slices
    always_comb
    begin
        if (pass_upper)
        begin
            reg_pick = upper_q;
        end
        else if (pass_lower)
        begin
            reg_pick = lower_q;
        end
        else
        begin
            reg_pick = bleg_pkg::CONST_ZERO;
        end
    end

    // bits 15:4 come from a register only while no constant is chosen
    always_comb
    begin
        if (high_enable)
        begin
            high_part = reg_pick & ~bleg_pkg::HIGH_CLEAR_MASK;
        end
        else
        begin
            high_part = bleg_pkg::CONST_ZERO;
        end
    end

    // bits 3:0 from the chosen register
    always_comb
    begin
        low_part = reg_pick & bleg_pkg::HIGH_CLEAR_MASK;
    end

    // constant generator; the +16 preset is the one constant with a
    // bit above the low nibble, so it bypasses the high-bit clear
    always_comb
    begin
        if (gen_sixteen)
        begin
            const_part = bleg_pkg::CONST_SIXTEEN;
        end
        else if (gen_unit && SUPPRESS_UNIT_CONSTANT)
        begin
            const_part = bleg_pkg::CONST_ZERO;
        end
        else if (gen_unit)
        begin
            const_part = bleg_pkg::CONST_ONE;
        end
        else
        begin
            const_part = bleg_pkg::CONST_ZERO;
        end
    end

    // no register in the merge, so the ALU sees a new code same cycle
    always_comb
    begin
        b_next = high_part | low_part | const_part;
    end

    assign B_OPERAND = b_next;
    assign UPPER_Q = upper_q;
    assign LOWER_Q = lower_q;
endmodule

// ==== pkg/bleg_pkg.sv ====
package bleg_pkg;
    localparam int WORD_W = 16;
    localparam int SS_DEPTH = 16;
    localparam int SS_AW = 4;

    // scratch store entry roles (octal numbering)
    localparam logic [3:0] SS_STACK_PTR = 4'h6;
    localparam logic [3:0] SS_PROG_CNT = 4'h7;
    localparam logic [3:0] SS_USER_SP = 4'he;   // octal 16
    localparam logic [3:0] SS_UNUSED_A = 4'h9;  // octal 11
    localparam logic [3:0] SS_UNUSED_B = 4'hc;  // octal 14

    // shifter mode selects {sel1, sel0}
    typedef enum logic [1:0] {
        MODE_HOLD  = 2'b00,
        MODE_RIGHT = 2'b01,
        MODE_LEFT  = 2'b10,
        MODE_LOAD  = 2'b11
    } shift_mode_t;

    // b operand selector codes {sel1, sel0}
    typedef enum logic [1:0] {
        BSEL_UPPER = 2'b00,
        BSEL_LOWER = 2'b01,
        BSEL_SIXTEEN = 2'b10,
        BSEL_UNIT = 2'b11
    } bsel_t;

    localparam logic [15:0] CONST_SIXTEEN = 16'h0010;
    localparam logic [15:0] CONST_ONE = 16'h0001;
    localparam logic [15:0] CONST_ZERO = 16'h0000;
    localparam logic [15:0] HIGH_CLEAR_MASK = 16'h000f;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam int BYTE_MSB = 7;
    localparam int WORD_MSB = 15;

    // scratch store access
    typedef struct packed {
        logic [3:0]  addr;
        logic        wr_en;
        logic [3:0]  wr_addr;
        logic [15:0] wr_data;
    } ss_req_t;

    // shifter controls
    typedef struct packed {
        shift_mode_t upper_mode;
        shift_mode_t lower_mode;
        logic        byte_op;
        logic        shift_in_upper;
        logic        serial_shift;
        logic        shift_in_lower;
    } shift_ctl_t;
endpackage
